// ### tsec_core_model.sv
// Far-side model: peripheral request lines and the core's stack capture
`timescale 1ns/1ps
`default_nettype none
module tsec_core_model (
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Peripheral request control from the bench
   input  wire logic [tsec_pkg::NUM_SRC-1:0]  set_i,
   input  wire logic [tsec_pkg::NUM_SRC-1:0]  clr_i,
   output logic      [tsec_pkg::NUM_SRC-1:0]  src_req_o,
   // State words pushed by the controller
   input  wire tsec_pkg::tsec_word_t          push_i,
   output logic      [tsec_pkg::ADDR_W-1:0]   word0_o,
   output logic      [tsec_pkg::ADDR_W-1:0]   word1_o
);
   import tsec_pkg::*;

   // Level requests stay up until the source is told to drop them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_req_o <= VEC_ZERO;
      end else begin
         src_req_o <= (src_req_o | set_i) & ~clr_i;
      end
   end

   // Stack capture: the older of the last two pushed words is the return pc
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word0_o <= ADDR_ZERO;
         word1_o <= ADDR_ZERO;
      end else if (push_i.valid) begin
         word0_o <= word1_o;
         word1_o <= push_i.data;
      end
   end
endmodule
`default_nettype wire

// ### tsec_core_stage.sv
// Core event stage: latches, masks, prioritises and delivers events to the core
`timescale 1ns/1ps
`default_nettype none
module tsec_core_stage (
   // Clock and reset
   input  wire logic                            clk_i,
   input  wire logic                            rst_i,
   // Dedicated event sources
   input  wire logic                            emu_req_i,
   input  wire logic                            rst_req_i,
   input  wire logic                            nmi_pin_i,
   input  wire logic                            wdog_expire_i,
   input  wire logic                            exc_align_i,
   input  wire logic                            exc_undef_i,
   // Software raise
   input  wire logic                            swi_req_i,
   input  wire logic [tsec_pkg::LVL_W-1:0]      swi_level_i,
   // Peripheral requests and their routing
   input  wire logic [tsec_pkg::NUM_SRC-1:0]    src_req_i,
   input  wire logic                            assign_we_i,
   input  wire logic [tsec_pkg::SRC_IDX_W-1:0]  assign_idx_i,
   input  wire logic [tsec_pkg::LVL_W-1:0]      assign_level_i,
   // Unmask control
   input  wire logic                            unmask_we_i,
   input  wire logic [tsec_pkg::NUM_EVT-1:0]    unmask_i,
   // Core side
   input  wire logic [tsec_pkg::ADDR_W-1:0]     pc_i,
   input  wire logic                            ret_i,
   input  wire logic [tsec_pkg::LVL_W-1:0]      ret_level_i,
   // Delivery and state towards the core
   output tsec_pkg::tsec_take_t                 take_o,
   output tsec_pkg::tsec_word_t                 push_o,
   output tsec_pkg::tsec_word_t                 resume_o,
   output logic                                 emu_mode_o,
   output logic                                 core_reset_o,
   output logic                                 insn_abort_o,
   output logic      [tsec_pkg::NUM_EVT-1:0]    event_latch_bits_o,
   output logic      [tsec_pkg::NUM_EVT-1:0]    pending_o
);
   import tsec_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_SAVE_ST, S_DELIVER, S_RESUME} tsec_state_t;

   tsec_state_t        state;
   tsec_state_t        next_state;
   logic [NUM_EVT-1:0] event_unmask_bits;
   logic [NUM_EVT-1:0] next_event_unmask_bits;
   logic [NUM_EVT-1:0] next_event_latch_bits;
   logic [NUM_EVT-1:0] next_pending;
   logic [LVL_W-1:0]   cur;
   logic [LVL_W-1:0]   next_cur;
   tsec_take_t         next_take;
   tsec_word_t         next_push;
   tsec_word_t         next_resume;
   logic               next_emu_mode;
   logic               next_core_reset;
   logic               next_insn_abort;
   logic [NUM_EVT-1:0] level_req;
   logic [NUM_EVT-1:0] raise_vec;
   logic [NUM_EVT-1:0] eff;
   logic [LVL_W:0]     cand;
   logic [LVL_W:0]     top_pend;
   logic               accept;
   logic               ret_go;
   logic               raise_at_cand;
   logic [ADDR_W-1:0]  ret_rdata;

   // Lowest set index wins; top bit flags that any bit is set
   function automatic logic [LVL_W:0] first_set(input logic [NUM_EVT-1:0] v);
      logic [LVL_W:0] r;
      r = {1'b0, EVT_EMU};
      for (int i = NUM_EVT-1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, LVL_W'(i)};
         end
      end
      return r;
   endfunction

   // Class of an event slot
   function automatic tsec_class_t class_of(input logic [LVL_W-1:0] lvl);
      tsec_class_t c;
      c = CLS_INT;
      if (lvl == EVT_EMU) begin
         c = CLS_EMU;
      end else if (lvl == EVT_RST) begin
         c = CLS_RST;
      end else if (lvl == EVT_NMI) begin
         c = CLS_NMI;
      end else if (lvl == EVT_EXC) begin
         c = CLS_EXC;
      end
      return c;
   endfunction

   // System stage feeds the general levels
   tsec_sys_stage u_sys (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .src_req_i      (src_req_i),
      .assign_we_i    (assign_we_i),
      .assign_idx_i   (assign_idx_i),
      .assign_level_i (assign_level_i),
      .level_req_o    (level_req)
   );

   // Per-slot return addresses
   tsec_ret_mem u_ret (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (accept),
      .waddr_i (cand[LVL_W-1:0]),
      .wdata_i (pc_i),
      .raddr_i (ret_level_i),
      .rdata_o (ret_rdata)
   );

   // Raise vector from all sources, masked to live slots
   always_comb begin
      raise_vec           = level_req & gen_mask();
      raise_vec[EVT_EMU]  = emu_req_i;
      raise_vec[EVT_RST]  = rst_req_i;
      raise_vec[EVT_NMI]  = nmi_pin_i | wdog_expire_i;
      raise_vec[EVT_EXC]  = exc_align_i | exc_undef_i;
      if (swi_req_i && swi_level_i >= LVL_FIRST) begin
         raise_vec[swi_level_i] = 1'b1;
      end
      raise_vec = raise_vec & LIVE_EVTS;
   end

   function automatic logic [NUM_EVT-1:0] gen_mask();
      return LIVE_EVTS & ~FIXED_UNMASK;
   endfunction

   // Candidate selection against the nesting level
   always_comb begin
      eff           = event_latch_bits_o & (event_unmask_bits | FIXED_UNMASK);
      cand          = first_set(eff);
      top_pend      = first_set(pending_o);
      accept        = (state == S_IDLE) && cand[LVL_W] &&
                      (!top_pend[LVL_W] || cand[LVL_W-1:0] < top_pend[LVL_W-1:0] ||
                       cand[LVL_W-1:0] == EVT_RST);
      ret_go        = (state == S_IDLE) && !accept && ret_i && pending_o[ret_level_i];
      raise_at_cand = raise_vec[cand[LVL_W-1:0]];
   end

   // Next-state logic for the whole event sequencer
   always_comb begin
      next_state             = state;
      next_cur               = cur;
      next_event_unmask_bits = unmask_we_i ? unmask_i : event_unmask_bits;
      next_pending           = pending_o;
      next_take              = '{take: 1'b0, level: cur, cls: class_of(cur)};
      next_push              = '{valid: 1'b0, data: push_o.data};
      next_resume            = '{valid: 1'b0, data: resume_o.data};
      next_emu_mode          = emu_mode_o;
      next_core_reset        = 1'b0;
      next_insn_abort        = insn_abort_o | raise_vec[EVT_EXC];
      // Accept clears the latch, a fresh raise in the same cycle wins
      next_event_latch_bits  = event_latch_bits_o;
      if (accept) begin
         next_event_latch_bits[cand[LVL_W-1:0]] = 1'b0;
      end
      next_event_latch_bits  = next_event_latch_bits | raise_vec;
      case (state)
         S_IDLE: begin
            if (accept && cand[LVL_W-1:0] == EVT_RST) begin
               next_core_reset        = 1'b1;
               next_pending           = VEC_ZERO;
               next_event_latch_bits  = raise_vec & ~(VEC_ZERO | (NUM_EVT'(1) << EVT_RST));
               next_event_unmask_bits = UNMASK_RST;
               next_emu_mode          = 1'b0;
               next_insn_abort        = 1'b0;
            end else if (accept) begin
               next_cur   = cand[LVL_W-1:0];
               next_push  = '{valid: 1'b1, data: pc_i};
               next_state = S_SAVE_ST;
            end else if (ret_go) begin
               next_cur   = ret_level_i;
               next_state = S_RESUME;
            end
         end
         S_SAVE_ST: begin
            next_push  = '{valid: 1'b1, data: {STATE_PAD, pending_o}};
            next_state = S_DELIVER;
         end
         S_DELIVER: begin
            next_take          = '{take: 1'b1, level: cur, cls: class_of(cur)};
            next_pending[cur]  = 1'b1;
            if (cur == EVT_EMU) begin
               next_emu_mode = 1'b1;
            end
            if (cur == EVT_EXC) begin
               next_insn_abort = raise_vec[EVT_EXC];
            end
            next_state = S_IDLE;
         end
         S_RESUME: begin
            next_resume       = '{valid: 1'b1, data: ret_rdata};
            next_pending[cur] = 1'b0;
            if (cur == EVT_EMU) begin
               next_emu_mode = 1'b0;
            end
            next_state = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state              <= S_IDLE;
         cur                <= EVT_EMU;
         event_unmask_bits  <= UNMASK_RST;
         event_latch_bits_o <= VEC_ZERO;
         pending_o          <= VEC_ZERO;
         take_o             <= '{take: 1'b0, level: EVT_EMU, cls: CLS_EMU};
         push_o             <= '{valid: 1'b0, data: ADDR_ZERO};
         resume_o           <= '{valid: 1'b0, data: ADDR_ZERO};
         emu_mode_o         <= 1'b0;
         core_reset_o       <= 1'b0;
         insn_abort_o       <= 1'b0;
      end else begin
         state              <= next_state;
         cur                <= next_cur;
         event_unmask_bits  <= next_event_unmask_bits;
         event_latch_bits_o <= next_event_latch_bits;
         pending_o          <= next_pending;
         take_o             <= next_take;
         push_o             <= next_push;
         resume_o           <= next_resume;
         emu_mode_o         <= next_emu_mode;
         core_reset_o       <= next_core_reset;
         insn_abort_o       <= next_insn_abort;
      end
   end

   // Checks on the sequencer
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_class_range;
      take_o.take |-> (take_o.cls == CLS_INT) == (take_o.level >= LVL_FIRST);
   endproperty
   a_class_range: assert property (p_class_range) else $error("Class and level disagree");

   property p_emu_mode;
      take_o.take && take_o.cls == CLS_EMU |-> emu_mode_o;
   endproperty
   a_emu_mode: assert property (p_emu_mode) else $error("Emulation taken without mode");

   property p_reset;
      accept && cand[LVL_W-1:0] == EVT_RST |=> core_reset_o && pending_o == VEC_ZERO && !emu_mode_o;
   endproperty
   a_reset: assert property (p_reset) else $error("Reset event did not reset state");

   property p_nmi_latch;
      nmi_pin_i || wdog_expire_i |=> event_latch_bits_o[EVT_NMI] || core_reset_o;
   endproperty
   a_nmi_latch: assert property (p_nmi_latch) else $error("NMI source not latched");

   property p_exc_abort;
      exc_align_i || exc_undef_i |=> insn_abort_o || core_reset_o;
   endproperty
   a_exc_abort: assert property (p_exc_abort) else $error("Exception did not abort instruction");

   property p_accept_clears;
      accept && cand[LVL_W-1:0] != EVT_RST && !raise_at_cand |=> !event_latch_bits_o[cur];
   endproperty
   a_accept_clears: assert property (p_accept_clears) else $error("Accepted latch not cleared");

   property p_masked_holds;
      state == S_IDLE && event_latch_bits_o[LVL_LAST] && !event_unmask_bits[LVL_LAST] && !accept
         |=> event_latch_bits_o[LVL_LAST];
   endproperty
   a_masked_holds: assert property (p_masked_holds) else $error("Masked latch was lost");

   property p_push_then_take;
      accept && cand[LVL_W-1:0] != EVT_RST |=> push_o.valid ##1 push_o.valid ##1 take_o.take;
   endproperty
   a_push_then_take: assert property (p_push_then_take) else $error("State not pushed before take");

   property p_resume;
      ret_go |-> ##2 resume_o.valid && !pending_o[cur];
   endproperty
   a_resume: assert property (p_resume) else $error("Return did not resume in two cycles");

   property p_priority;
      take_o.take |-> (pending_o & ~(VEC_ONES << take_o.level)) == VEC_ZERO;
   endproperty
   a_priority: assert property (p_priority) else $error("Lower priority event preempted higher");
endmodule
`default_nettype wire

// ### tsec_pkg.sv
// Constants, types and carriers shared by the two-stage event controller
// Overview of operation
// - Exactly five event classes are recognised
// - Emulation event enters emulation mode
// - Reset event resets the whole processor
// - Watchdog expiry or NMI pin raises NMI
// - Exception aborts faulting instruction before completion
// - Misalignment or undefined instruction raise exceptions
// - Interrupts accepted asynchronously to instruction flow
// - Interrupts from pins, timers, peripherals, software
// - Each class stores its own return address
// - Per-class return resumes from saved address
// - Taking an event pushes state on stack
// - Two cooperating stages: core and system
// - Peripheral requests routed through system stage
// - Nine general levels 7-15, lower wins
// - Default source mapping, reassignable per source
// - Latch bit sets on event, clears on accept
// - Cleared unmask bit blocks servicing, latch stays
package tsec_pkg;
   localparam int NUM_EVT   = 16;
   localparam int NUM_SRC   = 16;
   localparam int LVL_W     = 4;
   localparam int SRC_IDX_W = 4;
   localparam int ADDR_W    = 32;

   // Event slots in the latch, unmask and pending vectors
   localparam logic [LVL_W-1:0] EVT_EMU   = 4'h0;
   localparam logic [LVL_W-1:0] EVT_RST   = 4'h1;
   localparam logic [LVL_W-1:0] EVT_NMI   = 4'h2;
   localparam logic [LVL_W-1:0] EVT_EXC   = 4'h3;
   localparam logic [LVL_W-1:0] LVL_FIRST = 4'h7;
   localparam logic [LVL_W-1:0] LVL_LAST  = 4'hF;

   // Vector masks
   localparam logic [NUM_EVT-1:0] FIXED_UNMASK = 16'h000F;  // Dedicated classes cannot be masked
   localparam logic [NUM_EVT-1:0] LIVE_EVTS    = 16'hFF8F;  // Slots 4..6 are unused here
   localparam logic [NUM_EVT-1:0] UNMASK_RST   = 16'h0000;
   localparam logic [NUM_EVT-1:0] VEC_ZERO     = 16'h0000;
   localparam logic [NUM_EVT-1:0] VEC_ONES     = 16'hFFFF;
   localparam logic [ADDR_W-1:0]  ADDR_ZERO    = 32'h0000_0000;
   localparam logic [ADDR_W-NUM_EVT-1:0] STATE_PAD = 16'h0000;

   // Default level of each peripheral source, source 0 in the low nibble
   localparam logic [NUM_SRC*LVL_W-1:0] DEF_MAP = 64'hFEDC_BA98_DCBA_9877;

   // Event classes
   typedef enum logic [2:0] {CLS_EMU, CLS_RST, CLS_NMI, CLS_EXC, CLS_INT} tsec_class_t;

   // One word towards the core, with its strobe
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] data;
   } tsec_word_t;

   // Delivery of one event to the core
   typedef struct packed {
      logic             take;
      logic [LVL_W-1:0] level;
      tsec_class_t      cls;
   } tsec_take_t;
endpackage

// ### tsec_ret_mem.sv
// Return-address store, one word per event slot, registered read
`timescale 1ns/1ps
`default_nettype none
module tsec_ret_mem (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // Write port
   input  wire logic                         we_i,
   input  wire logic [tsec_pkg::LVL_W-1:0]   waddr_i,
   input  wire logic [tsec_pkg::ADDR_W-1:0]  wdata_i,
   // Read port
   input  wire logic [tsec_pkg::LVL_W-1:0]   raddr_i,
   output logic      [tsec_pkg::ADDR_W-1:0]  rdata_o
);
   import tsec_pkg::*;

   logic [ADDR_W-1:0] mem [NUM_EVT];

   // Storage array
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Registered read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= ADDR_ZERO;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule
`default_nettype wire

// ### tsec_sys_stage.sv
// System stage: maps peripheral requests onto the general levels of the core stage
`timescale 1ns/1ps
`default_nettype none
module tsec_sys_stage (
   // Clock and reset
   input  wire logic                            clk_i,
   input  wire logic                            rst_i,
   // Peripheral requests
   input  wire logic [tsec_pkg::NUM_SRC-1:0]    src_req_i,
   // Level assignment writes
   input  wire logic                            assign_we_i,
   input  wire logic [tsec_pkg::SRC_IDX_W-1:0]  assign_idx_i,
   input  wire logic [tsec_pkg::LVL_W-1:0]      assign_level_i,
   // Requests per core level
   output logic      [tsec_pkg::NUM_EVT-1:0]    level_req_o
);
   import tsec_pkg::*;

   logic [LVL_W-1:0]   src_level      [NUM_SRC];
   logic [NUM_EVT-1:0] next_level_req;

   // Per-source assignment register, defaulting to the reset map
   genvar s;
   generate
      for (s = 0; s < NUM_SRC; s++) begin : g_src
         logic [LVL_W-1:0] next_src_level;
         always_comb begin
            next_src_level = src_level[s];
            if (assign_we_i && assign_idx_i == SRC_IDX_W'(s) && assign_level_i >= LVL_FIRST) begin
               next_src_level = assign_level_i;
            end
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               src_level[s] <= DEF_MAP[s*LVL_W +: LVL_W];
            end else begin
               src_level[s] <= next_src_level;
            end
         end
      end
   endgenerate

   // Route every source onto its assigned general level
   always_comb begin
      next_level_req = VEC_ZERO;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (src_req_i[i]) begin
            next_level_req[src_level[i]] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_req_o <= VEC_ZERO;
      end else begin
         level_req_o <= next_level_req;
      end
   end
endmodule
`default_nettype wire

// ### two_stage_event_controller_tb.sv
// Self-checking testbench of the core event stage with its far-side model
`timescale 1ns/1ps
`default_nettype none
module two_stage_event_controller_tb;
   import tsec_pkg::*;

   // Design inputs
   logic clk_i, rst_i, emu_req_i, rst_req_i, nmi_pin_i, wdog_expire_i, exc_align_i, exc_undef_i;
   logic swi_req_i, assign_we_i, unmask_we_i, ret_i;
   logic [LVL_W-1:0] swi_level_i, assign_idx_i, assign_level_i, ret_level_i;
   logic [NUM_EVT-1:0] unmask_i, per_set, per_clr, src_req;
   logic [ADDR_W-1:0] pc_i, word0, word1;
   // Design outputs
   tsec_take_t take_o;
   tsec_word_t push_o, resume_o;
   logic emu_mode_o, core_reset_o, insn_abort_o;
   logic [NUM_EVT-1:0] event_latch_bits_o, pending_o;
   int fail_count, compares, cycles;
   logic got;

   tsec_core_stage dut (.clk_i(clk_i), .rst_i(rst_i), .emu_req_i(emu_req_i), .rst_req_i(rst_req_i),
      .nmi_pin_i(nmi_pin_i), .wdog_expire_i(wdog_expire_i), .exc_align_i(exc_align_i),
      .exc_undef_i(exc_undef_i), .swi_req_i(swi_req_i), .swi_level_i(swi_level_i), .src_req_i(src_req),
      .assign_we_i(assign_we_i), .assign_idx_i(assign_idx_i), .assign_level_i(assign_level_i),
      .unmask_we_i(unmask_we_i), .unmask_i(unmask_i), .pc_i(pc_i), .ret_i(ret_i), .ret_level_i(ret_level_i),
      .take_o(take_o), .push_o(push_o), .resume_o(resume_o), .emu_mode_o(emu_mode_o),
      .core_reset_o(core_reset_o), .insn_abort_o(insn_abort_o), .event_latch_bits_o(event_latch_bits_o),
      .pending_o(pending_o));

   tsec_core_model model (.clk_i(clk_i), .rst_i(rst_i), .set_i(per_set), .clr_i(per_clr),
      .src_req_o(src_req), .push_i(push_o), .word0_o(word0), .word1_o(word1));

   // Clock at 100 ns period
   initial begin
      clk_i = 1'h0;
      forever #50 clk_i = ~clk_i;
   end

   // Hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count = fail_count + 1;
         close_out();
      end
   end

   // Comparison and verdict
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("Checks made %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One-cycle request on a dedicated source (0..5) or a software raise (6)
   task automatic pulse(input int k, input logic [3:0] lvl, input logic [31:0] pc);
      @(posedge clk_i);
      pc_i <= pc;
      case (k)
         0: emu_req_i <= 1'h1;
         1: rst_req_i <= 1'h1;
         2: nmi_pin_i <= 1'h1;
         3: wdog_expire_i <= 1'h1;
         4: exc_align_i <= 1'h1;
         5: exc_undef_i <= 1'h1;
         default: begin
            swi_req_i <= 1'h1;
            swi_level_i <= lvl;
         end
      endcase
      @(posedge clk_i);
      {emu_req_i, rst_req_i, nmi_pin_i, wdog_expire_i, exc_align_i, exc_undef_i, swi_req_i} <= 7'h00;
   endtask

   // Bounded wait for a delivery strobe, sampled mid-cycle
   task automatic wait_take(input int lim);
      got = 1'h0;
      for (int n = 0; n < lim && !got; n++) begin
         @(negedge clk_i);
         got = (take_o.take === 1'h1);
      end
   endtask

   // Expect one delivery and the pushed return pc
   task automatic expect_take(input logic [3:0] el, input tsec_class_t ec, input logic [31:0] pc);
      wait_take(20);
      chk("take", got, 1'h1);
      chk("level", take_o.level, el);
      chk("class", take_o.cls, ec);
      chk("pushed pc", word0, pc);
      chk("pending bit", pending_o[el], 1'h1);
   endtask

   // Return from a slot and expect its saved address back
   task automatic do_return(input logic [3:0] lvl, input logic [31:0] exp);
      @(posedge clk_i);
      ret_i <= 1'h1;
      ret_level_i <= lvl;
      @(posedge clk_i);
      ret_i <= 1'h0;
      got = 1'h0;
      for (int n = 0; n < 10 && !got; n++) begin
         @(negedge clk_i);
         got = (resume_o.valid === 1'h1);
      end
      chk("resume", got, 1'h1);
      chk("resume addr", resume_o.data, exp);
      chk("pending clear", pending_o[lvl], 1'h0);
   endtask

   // Every dedicated class except reset, and its return
   task automatic t_classes();
      logic [3:0] lv [6] = '{EVT_EMU, EVT_NMI, EVT_NMI, EVT_EXC, EVT_EXC, EVT_EMU};
      tsec_class_t cl [6] = '{CLS_EMU, CLS_NMI, CLS_NMI, CLS_EXC, CLS_EXC, CLS_EMU};
      int kk [6] = '{0, 2, 3, 4, 5, 0};
      for (int i = 0; i < 5; i++) begin
         pulse(kk[i], 4'h0, 32'h0000_1000 + i);
         @(negedge clk_i);
         if (kk[i] >= 4) chk("abort", insn_abort_o, 1'h1);
         expect_take(lv[i], cl[i], 32'h0000_1000 + i);
         if (kk[i] == 0) chk("emu mode", emu_mode_o, 1'h1);
         do_return(lv[i], 32'h0000_1000 + i);
         @(negedge clk_i);
         chk("emu left", emu_mode_o, 1'h0);
         chk("abort done", insn_abort_o, 1'h0);
      end
      $display("Test classes done");
   endtask

   // Reset event wipes a masked latched level
   task automatic t_rst_event();
      pulse(6, 4'hF, 32'h0000_2000);
      repeat (3) @(negedge clk_i);
      chk("latched masked", event_latch_bits_o[15], 1'h1);
      pulse(1, 4'h0, 32'h0000_2000);
      got = 1'h0;
      for (int n = 0; n < 10 && !got; n++) begin
         @(negedge clk_i);
         got = (core_reset_o === 1'h1);
      end
      chk("core reset", got, 1'h1);
      @(negedge clk_i);
      chk("latch wiped", event_latch_bits_o, 16'h0000);
      chk("pending wiped", pending_o, 16'h0000);
      $display("Test reset event done");
   endtask

   // Masked software raise waits, then goes once unmasked
   task automatic t_mask();
      pulse(6, 4'hD, 32'h0000_3000);
      wait_take(12);
      chk("masked no take", got, 1'h0);
      chk("masked latched", event_latch_bits_o[13], 1'h1);
      @(posedge clk_i);
      unmask_we_i <= 1'h1;
      unmask_i <= 16'h2000;
      @(posedge clk_i);
      unmask_we_i <= 1'h0;
      expect_take(4'hD, CLS_INT, 32'h0000_3000);
      chk("latch cleared", event_latch_bits_o[13], 1'h0);
      do_return(4'hD, 32'h0000_3000);
      $display("Test mask done");
   endtask

   // Two peripheral sources at once on their default levels
   task automatic t_priority();
      @(posedge clk_i);
      unmask_we_i <= 1'h1;
      unmask_i <= 16'hFF80;
      pc_i <= 32'h0000_4000;
      per_set <= 16'h0005;
      @(posedge clk_i);
      unmask_we_i <= 1'h0;
      per_set <= 16'h0000;
      per_clr <= 16'h0005;
      // Sources drop after one cycle so an accepted level is not raised again
      @(posedge clk_i);
      per_clr <= 16'h0000;
      expect_take(4'h7, CLS_INT, 32'h0000_4000);
      wait_take(10);
      chk("lower waits", got, 1'h0);
      chk("lower kept", event_latch_bits_o[8], 1'h1);
      do_return(4'h7, 32'h0000_4000);
      expect_take(4'h8, CLS_INT, 32'h0000_4000);
      do_return(4'h8, 32'h0000_4000);
      $display("Test priority done");
   endtask

   // Reassigned source, then nesting by a higher class
   task automatic t_reassign();
      @(posedge clk_i);
      assign_we_i <= 1'h1;
      assign_idx_i <= 4'h0;
      assign_level_i <= 4'hC;
      pc_i <= 32'h0000_5000;
      @(posedge clk_i);
      assign_we_i <= 1'h0;
      per_set <= 16'h0001;
      @(posedge clk_i);
      per_set <= 16'h0000;
      per_clr <= 16'h0001;
      @(posedge clk_i);
      per_clr <= 16'h0000;
      expect_take(4'hC, CLS_INT, 32'h0000_5000);
      pulse(2, 4'h0, 32'h0000_5100);
      expect_take(EVT_NMI, CLS_NMI, 32'h0000_5100);
      chk("pushed state", word1, 32'h0000_1000);
      do_return(EVT_NMI, 32'h0000_5100);
      do_return(4'hC, 32'h0000_5000);
      $display("Test reassign done");
   endtask

   // Main sequence
   initial begin
      fail_count = 0;
      compares = 0;
      cycles = 0;
      rst_i = 1'h1;
      {emu_req_i, rst_req_i, nmi_pin_i, wdog_expire_i, exc_align_i, exc_undef_i, swi_req_i} = 7'h00;
      {assign_we_i, unmask_we_i, ret_i} = 3'h0;
      {swi_level_i, assign_idx_i, assign_level_i, ret_level_i} = 16'h0000;
      unmask_i = 16'h0000;
      per_set = 16'h0000;
      per_clr = 16'h0000;
      pc_i = 32'h0000_0000;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      @(negedge clk_i);
      chk("idle latch", event_latch_bits_o, 16'h0000);
      t_classes();
      t_rst_event();
      t_mask();
      t_priority();
      t_reassign();
      close_out();
   end
endmodule
`default_nettype wire
